// *** design/adc_port_pkg.sv ***
// constants and state types shared by the adc serial port design
// assumes a 10 MHz system clock and a host-driven serial clock
package adc_port_pkg;
  localparam int RESULT_BITS    = 14;
  localparam int CTRL_BITS      = 8;
  // control byte field positions
  localparam int CTRL_START_POS = 7;
  localparam int CTRL_BIP_POS   = 6;
  localparam int CTRL_INT_POS   = 5;
  // power-on defaults of the mode settings
  localparam logic RST_INT_MODE = 1'b1;
  localparam logic RST_BIPOLAR  = 1'b0;
  // sign flip turns offset binary samples into two's complement
  localparam logic [RESULT_BITS-1:0] SIGN_FLIP = 14'h2000;
  localparam int BUF_DEPTH      = 2;
  // internal-clock conversion time, rounded up to system clocks
  localparam int CLK_PERIOD_NS  = 100;
  localparam int INT_CONV_NS    = 5000;
  localparam int INT_CONV_CYCLES =
    (INT_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {LINK_IDLE, LINK_EXT_STROBE, LINK_INT_WAIT, LINK_SHIFT}
    link_state_t;
  typedef enum {CONV_IDLE, CONV_BUSY} conv_state_t;
endpackage

// *** design/word_stream_if.sv ***
// valid/ready word stream between the port logic and its buffer
// assumes both ends run on the same clock
interface word_stream_if #(parameter int WIDTH = 14);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// *** design/word_buffer.sv ***
// small flip-flop fifo with valid/ready on both sides
// assumes synchronous active-high reset on the write/read clock
module word_buffer #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input  wire logic       clk,   // buffer clock
  input  wire logic       rst,   // synchronous reset, high
  word_stream_if.sink     wr,    // filling side
  word_stream_if.source   rd     // draining side
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign wr.ready = (count != CW'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rd_ptr];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule

// *** design/serial_adc_result_strobe_port.sv ***
// serial port and conversion strobe of a 14-bit sar converter
// assumes samples arrive as offset-binary words on sample_*; the serial
// clock, chip select and data input come from the host on sclk
// Overview of operation
// R1 - internal clock: strobe low at conversion start, high when done
// R2 - external clock: strobe high one serial period just before the msb
// R3 - external clock: strobe pin released while chip select is high
// R4 - result leaves msb first, straight binary in unipolar range
// R5 - bipolar range: result leaves in two's complement
// R6 - next result bit appears on each falling serial clock edge
// R7 - reset pin low abandons activity, restores power-on settings
// R8 - shutdown pin low puts the device into its power-down state
// R9 - host waits for strobe rise before clocking out internal results
// R10 - serial input bits are captured on rising serial clock edges
// R11 - first one bit after select or conversion starts the control byte
// R12 - serial data pin released whenever chip select is high
// R13 - in external clock mode the serial clock paces the conversion
// R14 - fourteen result bits per conversion, one per falling edge
module serial_adc_result_strobe_port #(
  parameter int RESULT_BITS = adc_port_pkg::RESULT_BITS,
  parameter int CONV_CYCLES = adc_port_pkg::INT_CONV_CYCLES
) (
  input  wire logic                   clk_sys,      // system clock
  input  wire logic                   sys_rst,      // sync reset, high
  input  wire logic                   sclk,         // host serial clock
  input  wire logic                   cs_n,         // chip select, low
  input  wire logic                   sdi,          // serial data in
  output logic                        dout,         // serial data out
  output logic                        dout_oe_n,    // dout driven, low
  output logic                        conversion_strobe,    // strobe
  output logic                        conversion_strobe_oe_n, // low=drive
  input  wire logic                   device_rst_n, // reset pin, low
  input  wire logic                   power_down_n, // shutdown pin, low
  input  wire logic [RESULT_BITS-1:0] sample_data,  // offset-binary word
  input  wire logic                   sample_valid, // sample offered
  output logic                        sample_ready, // buffer has room
  output logic                        shut_down     // in power-down
);
  localparam int IW = $clog2(RESULT_BITS);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [IW-1:0] LAST_BIT = IW'(RESULT_BITS - 1);

  // system domain
  logic [1:0]             rst_sync;
  logic [1:0]             pwr_sync;
  logic [2:0]             start_sync;
  logic [2:0]             done_sync;
  logic [1:0]             mode_sync;
  logic                   link_hold;
  logic                   dev_clear;
  logic                   start_ev;
  logic                   done_ev;
  logic [RESULT_BITS-1:0] staged_word;
  logic                   staged_full;
  adc_port_pkg::conv_state_t conv_state;
  logic [CW-1:0]          conv_cnt;
  logic                   strobe_int;
  // link domain
  logic                   link_clr;
  adc_port_pkg::link_state_t link_state;
  logic [2:0]             rx_cnt;
  logic [adc_port_pkg::CTRL_BITS-2:0] rx_sh;
  logic [IW-1:0]          bit_idx;
  logic                   byte_done;
  logic                   shift_done;
  logic                   start_tgl;
  logic                   done_tgl;
  logic                   int_mode;
  logic                   bipolar;
  logic [RESULT_BITS-1:0] coded_word;
  logic                   dout_q;
  logic                   strobe_ext;

  word_stream_if #(.WIDTH(RESULT_BITS)) fill_s ();
  word_stream_if #(.WIDTH(RESULT_BITS)) drain_s ();

  assign fill_s.valid  = sample_valid;
  assign fill_s.data   = sample_data;
  assign sample_ready  = fill_s.ready;
  assign drain_s.ready = !staged_full;

  word_buffer #(.WIDTH(RESULT_BITS), .DEPTH(adc_port_pkg::BUF_DEPTH)) buf_i (
    .clk (clk_sys),
    .rst (dev_clear),
    .wr  (fill_s),
    .rd  (drain_s)
  );

  // pins and link toggles cross on two flops before use
  // pin stages reset to the pins' idle high level, so sys_rst is not
  // followed by a false device reset or a shut_down pulse
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_sync   <= '1;
      pwr_sync   <= '1;
      start_sync <= '0;
      done_sync  <= '0;
      mode_sync  <= {2{adc_port_pkg::RST_INT_MODE}};
    end else begin
      rst_sync   <= {rst_sync[0], device_rst_n};
      pwr_sync   <= {pwr_sync[0], power_down_n};
      // the hold clears the toggles, so flush their stages with them;
      // otherwise the clear looks like a done event and drops a word
      start_sync <= link_hold ? '0 : {start_sync[1:0], start_tgl};
      done_sync  <= link_hold ? '0 : {done_sync[1:0], done_tgl};
      mode_sync  <= {mode_sync[0], int_mode};
    end
  end

  assign dev_clear = sys_rst || !rst_sync[1];                 // [R7]
  assign start_ev  = start_sync[2] ^ start_sync[1];
  assign done_ev   = done_sync[2] ^ done_sync[1];

  // holding the link in reset abandons any transfer in flight
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link_hold <= 1'b1;
      shut_down <= 1'b0;
    end else begin
      link_hold <= !rst_sync[1] || !pwr_sync[1];              // [R7] [R8]
      shut_down <= !pwr_sync[1];                              // [R8]
    end
  end

  // one word staged for the link; it stays put until the link is done
  always_ff @(posedge clk_sys) begin
    if (dev_clear) begin
      staged_full <= 1'b0;
      staged_word <= '0;
    end else if (done_ev) begin
      staged_full <= 1'b0;
    end else if (!staged_full && drain_s.valid) begin
      staged_full <= 1'b1;
      staged_word <= drain_s.data;
    end
  end

  // internal-clock conversion timing
  always_ff @(posedge clk_sys) begin
    if (dev_clear || link_hold) begin
      conv_state <= adc_port_pkg::CONV_IDLE;
      conv_cnt   <= '0;
      strobe_int <= 1'b1;
    end else begin
      unique case (conv_state)
        adc_port_pkg::CONV_IDLE: begin
          if (start_ev && mode_sync[1]) begin
            conv_state <= adc_port_pkg::CONV_BUSY;
            conv_cnt   <= CW'(CONV_CYCLES - 1);
            strobe_int <= 1'b0;                               // [R1]
          end
        end
        adc_port_pkg::CONV_BUSY: begin
          if (conv_cnt != '0) begin
            conv_cnt <= conv_cnt - 1'b1;
          end else if (staged_full) begin
            // a missing sample stretches the conversion, never fakes it
            conv_state <= adc_port_pkg::CONV_IDLE;
            strobe_int <= 1'b1;                               // [R1]
          end
        end
      endcase
    end
  end

  // link side: frames end with chip select, so it clears the link
  assign link_clr   = cs_n || link_hold;
  assign byte_done  = (link_state == adc_port_pkg::LINK_IDLE) &&
                      (rx_cnt == 3'h7);
  assign shift_done = (link_state == adc_port_pkg::LINK_SHIFT) &&
                      (bit_idx == LAST_BIT);

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      link_state <= adc_port_pkg::LINK_IDLE;
      rx_cnt     <= '0;
      rx_sh      <= '0;
      bit_idx    <= '0;
    end else begin
      unique case (link_state)
        adc_port_pkg::LINK_IDLE: begin
          if (rx_cnt == 3'h0) begin
            if (sdi) begin                                    // [R11] [R10]
              rx_cnt <= 3'h1;
              rx_sh  <= 7'h01;
            end
          end else if (byte_done) begin
            rx_cnt     <= '0;
            link_state <= int_mode_next() ? adc_port_pkg::LINK_INT_WAIT
                                          : adc_port_pkg::LINK_EXT_STROBE;
          end else begin
            rx_cnt <= rx_cnt + 3'h1;
            rx_sh  <= {rx_sh[5:0], sdi};                      // [R10]
          end
        end
        adc_port_pkg::LINK_EXT_STROBE,
        adc_port_pkg::LINK_INT_WAIT: begin
          link_state <= adc_port_pkg::LINK_SHIFT;             // [R13] [R9]
          bit_idx    <= '0;
        end
        adc_port_pkg::LINK_SHIFT: begin
          if (shift_done) begin
            link_state <= adc_port_pkg::LINK_IDLE;            // [R11] [R14]
          end else begin
            bit_idx <= bit_idx + 1'b1;                        // [R14]
          end
        end
      endcase
    end
  end

  function automatic logic int_mode_next();
    int_mode_next = rx_sh[adc_port_pkg::CTRL_INT_POS - 1];
  endfunction

  // mode bits and toggles outlive a frame, so only the hold clears them
  always_ff @(posedge sclk or posedge link_hold) begin
    if (link_hold) begin
      start_tgl <= 1'b0;
      done_tgl  <= 1'b0;
      int_mode  <= adc_port_pkg::RST_INT_MODE;               // [R7]
      bipolar   <= adc_port_pkg::RST_BIPOLAR;                // [R7]
    end else if (!cs_n) begin
      if (byte_done) begin
        start_tgl <= !start_tgl;
        int_mode  <= rx_sh[adc_port_pkg::CTRL_INT_POS - 1];
        bipolar   <= rx_sh[adc_port_pkg::CTRL_BIP_POS - 1];
      end
      if (shift_done) begin
        done_tgl <= !done_tgl;
      end
    end
  end

  // staged_word is quiet while staged_full is set; only the internal-clock strobe waits for that before the link reads it
  assign coded_word = bipolar ? (staged_word ^ adc_port_pkg::SIGN_FLIP)
                              : staged_word;                  // [R4] [R5]

  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      dout_q     <= 1'b0;
      strobe_ext <= 1'b0;
    end else begin
      strobe_ext <= (link_state == adc_port_pkg::LINK_EXT_STROBE); // [R2]
      if (link_state == adc_port_pkg::LINK_SHIFT) begin
        dout_q <= coded_word[LAST_BIT - bit_idx];             // [R4] [R6]
      end
    end
  end

  assign dout                   = dout_q;
  assign dout_oe_n              = cs_n;                       // [R12]
  assign conversion_strobe      = int_mode ? strobe_int : strobe_ext;
  assign conversion_strobe_oe_n = int_mode ? 1'b0 : cs_n;     // [R3]

  conv_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (conv_state == adc_port_pkg::CONV_IDLE && start_ev && mode_sync[1] &&
     !dev_clear && !link_hold) |=> !strobe_int [*2])
    else $error("strobe not low at conversion start"); // [R1]
  conv_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (conv_state == adc_port_pkg::CONV_BUSY && conv_cnt == '0 &&
     staged_full && !dev_clear && !link_hold) |=> strobe_int)
    else $error("strobe not high after conversion"); // [R1]
  ext_pulse_a: assert property (@(negedge sclk) disable iff (link_clr)
    $rose(strobe_ext) |=> !strobe_ext ##0
    link_state == adc_port_pkg::LINK_SHIFT)
    else $error("external strobe wider than one period"); // [R2]
  strobe_float_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cs_n && !int_mode) |-> conversion_strobe_oe_n)
    else $error("strobe driven while deselected"); // [R3]
  dout_bit_a: assert property (@(negedge sclk) disable iff (link_clr)
    (link_state == adc_port_pkg::LINK_SHIFT) |=>
    dout_q == $past(coded_word[LAST_BIT - bit_idx]))
    else $error("serial output bit wrong"); // [R4] [R5] [R6]
  bit_count_a: assert property (@(posedge sclk) disable iff (link_clr)
    (link_state != adc_port_pkg::LINK_SHIFT ##1
     link_state == adc_port_pkg::LINK_SHIFT) |->
    bit_idx == '0 ##13 shift_done)
    else $error("result length not fourteen bits"); // [R14]
  start_bit_a: assert property (@(posedge sclk) disable iff (link_clr)
    (link_state == adc_port_pkg::LINK_IDLE && rx_cnt == 3'h0 && !sdi)
    |=> rx_cnt == 3'h0)
    else $error("zero taken as start bit"); // [R11]
  dev_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rst_sync[1] |=> (!staged_full && strobe_int && link_hold))
    else $error("reset pin did not restore defaults"); // [R7]
  shutdown_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pwr_sync[1] |=> (shut_down && link_hold))
    else $error("shutdown pin ignored"); // [R8]
endmodule

// *** tb/host_model.sv ***
// host side of the serial link: chip select, serial clock, control bits
// assumes the bench resolves released pins to z before they reach here
module host_model (
  output logic      sclk,    // serial clock, still between frames
  output logic      cs_n,    // chip select, low
  output logic      sdi,     // control bits toward the port
  input  wire logic dout_w,  // resolved data pin
  input  wire logic strb_w   // resolved strobe pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // data changes only while the clock is low, ahead of the rise
  task automatic clock_bit(input logic d);
    sdi = d;
    #7.5 sclk = 1'b1;
    #7.5 sclk = 1'b0;
  endtask

  task automatic frame(input logic [7:0] ctrl, input int lead,
                       output logic [13:0] word, output logic s1,
                       output logic s2, output logic ok);
    int n;
    ok = 1'b1;
    cs_n = 1'b0;
    #103;
    for (n = 0; n < lead; n++) clock_bit(1'b0);
    for (n = 7; n >= 0; n--) clock_bit(ctrl[n]);
    #3 s1 = strb_w;
    if (ctrl[5]) begin
      // clock stays still until the strobe rises again
      for (n = 0; n < 100 && strb_w !== 1'b0; n++) #10;
      s1 = strb_w;
      for (n = 0; n < 2000 && strb_w !== 1'b1; n++) #10;
      ok = (strb_w === 1'b1);
    end
    clock_bit(1'b0);
    #3 s2 = strb_w;
    // in external mode these edges also pace the conversion
    for (n = 13; n >= 0; n--) begin
      #7.5 sclk = 1'b1;
      word[n] = dout_w;
      #7.5 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
  endtask
endmodule

// *** tb/serial_adc_result_strobe_port_tb.sv ***
// self-checking bench: sample queue model against the serial readout
// assumes the design guards its own timing with built-in assertions
module serial_adc_result_strobe_port_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys;
  logic        sys_rst;
  logic        device_rst_n;
  logic        power_down_n;
  logic        sample_valid;
  logic [13:0] sample_data;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        dout;
  logic        dout_oe_n;
  logic        conversion_strobe;
  logic        conversion_strobe_oe_n;
  logic        sample_ready;
  logic        shut_down;
  wire logic   dout_w;
  wire logic   strb_w;
  int          exp_q[$];
  int          bad_count;
  int          check_count;
  int          m;

  assign dout_w = dout_oe_n ? 1'bz : dout;
  assign strb_w = conversion_strobe_oe_n ? 1'bz : conversion_strobe;

  serial_adc_result_strobe_port #(.CONV_CYCLES(3))
    serial_adc_result_strobe_port_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .dout(dout), .dout_oe_n(dout_oe_n),
    .conversion_strobe(conversion_strobe),
    .conversion_strobe_oe_n(conversion_strobe_oe_n),
    .device_rst_n(device_rst_n), .power_down_n(power_down_n),
    .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .shut_down(shut_down));

  host_model host_model_inst (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .dout_w(dout_w),
    .strb_w(strb_w));

  task automatic check_bit(input string what, input logic e,
                           input logic g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic check_word(input string what, input logic [13:0] e,
                            input logic [13:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // valid is held until the edge that sees ready high
  task automatic push(input logic [13:0] w);
    int n;
    @(posedge clk_sys) #1;
    sample_data  = w;
    sample_valid = 1'b1;
    for (n = 0; n < 200 && sample_ready !== 1'b1; n++) @(posedge clk_sys) #1;
    if (n == 200) begin
      bad_count++;
      close_out();
    end
    @(posedge clk_sys) #1;
    sample_valid = 1'b0;
    exp_q.push_back(int'(w));
  endtask

  task automatic run_frame(input logic bip, input logic intm,
                           input int lead);
    logic [13:0] w;
    logic        s1;
    logic        s2;
    logic        ok;
    int          e;
    host_model_inst.frame({1'b1, bip, intm, 5'($urandom)}, lead,
                          w, s1, s2, ok);
    #1;
    e = exp_q.pop_front();
    // offset binary to two's complement is a half-scale rotation
    if (bip) e = (e + 8192) % 16384;
    check_word("result", 14'(e), w);
    check_bit("strobe_first", !intm, s1);
    check_bit("strobe_second", intm, s2);
    check_bit("conv_done", 1'b1, ok);
    check_bit("dout_released", 1'b1, dout_oe_n);
    check_bit("strobe_released", !intm, conversion_strobe_oe_n);
    repeat (6) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    sys_rst      = 1'b1;
    device_rst_n = 1'b1;
    power_down_n = 1'b1;
    sample_valid = 1'b0;
    sample_data  = 14'h0000;
    bad_count    = 0;
    check_count  = 0;
    void'($urandom(16));
    repeat (12) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check_bit("shut_down_early", 1'b0, shut_down);
    repeat (4) @(posedge clk_sys);
    #1;
    check_bit("shut_down", 1'b0, shut_down);
    check_bit("room", 1'b1, sample_ready);
    repeat (3) push(14'($urandom));
    check_bit("full", 1'b0, sample_ready);
    $display("test fill done");
    for (m = 0; m < 4; m++) begin
      run_frame(m[0], m[1], m);
      push(14'($urandom));
    end
    $display("test modes done");
    @(posedge clk_sys) #1;
    device_rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 device_rst_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    exp_q.delete();
    check_bit("room_after_reset", 1'b1, sample_ready);
    push(14'($urandom));
    repeat (6) @(posedge clk_sys);
    run_frame(1'b0, 1'b1, 0);
    $display("test reset done");
    @(posedge clk_sys) #1;
    power_down_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check_bit("shut_down", 1'b1, shut_down);
    power_down_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check_bit("shut_down", 1'b0, shut_down);
    $display("test shutdown done");
    close_out();
  end
endmodule
